// ===== hdl/elr_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Route any of the event types straight to destinations, no software.
// - Timer reaction to a linked event is set by configuration.
// - Port linking exists only on port B and port E.
// - Single-port linking drives exactly one configured pin.
// - Port-group linking drives any configured subset of eight pins.
// - Module stop halts routing; release resumes it.
// - One select register per listed destination index only.
// - Each select register holds an 8-bit source selector.
// - Two-bit field picks timer channel 8 reaction to its event.
// - Destination 28 requests clock switch to low-speed oscillator.
// - Codes 01h-06h timer 0 matches A-F, 07h overflow.
// - Codes 10h-13h timer 3 matches A-D, 14h overflow.
// - Codes 15h-18h timer 4 matches, 19h overflow, 1Ah underflow.
// - Codes 1Eh-21h timer 6 matches A-D, 22h overflow.
// - Codes 23h-26h timer 7 matches, 27h overflow, 28h underflow.
// - Codes 29h-2Ch timer 8 matches A-D, 2Dh overflow.
// - Code 37h compare timer channel 1 match.
// - Codes 3Ch-47h byte timers 0-3: match A, match B, overflow.
module elr_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pclk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [elr_pkg::ELR_ADDR_W-1:0] paddr,
   input wire logic [elr_pkg::ELR_DATA_W-1:0] pwdata,
   output logic [elr_pkg::ELR_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [elr_pkg::ELR_NUM_SRC-1:0] event_src,
   output logic [elr_pkg::ELR_NUM_DEST-1:0] dest_event,
   output logic lsosc_switch_req,
   output logic [elr_pkg::ELR_OP_W-1:0] timer8_link_op_select,
   output logic [elr_pkg::ELR_PORT_W-1:0] port_b_event,
   output logic [elr_pkg::ELR_PORT_W-1:0] port_e_event,
   output logic module_stopped
);
   import elr_pkg::*;

   // ==========================================
   // Bus decode
   logic [ELR_IDX_W-1:0] idx;
   logic wr_en;
   logic hit_dest;
   logic hit_any;
   logic [ELR_NUM_DEST-1:0] dest_hit;
   logic [ELR_NUM_SPORT-1:0] sport_hit;
   logic [ELR_DATA_W-1:0] rd_data;

   logic [ELR_SEL_W-1:0] link_select_reg_q [ELR_NUM_DEST];
   logic [ELR_OP_W-1:0] timer_link_op_reg_q;
   logic stop_q;
   logic badsel_q;
   logic [ELR_PORT_W-1:0] pg_mask_b_q;
   logic [ELR_PORT_W-1:0] pg_mask_e_q;
   logic [ELR_SP_EN_BIT:0] sport_cfg_q [ELR_NUM_SPORT];
   logic [ELR_NUM_DEST-1:0] dest_d;
   logic [ELR_NUM_DEST-1:0] dest_q;
   logic [ELR_PORT_W-1:0] port_b_d;
   logic [ELR_PORT_W-1:0] port_e_d;
   logic [ELR_PORT_W-1:0] port_b_q;
   logic [ELR_PORT_W-1:0] port_e_q;
   logic [ELR_DATA_W-1:0] prdata_q;
   logic badsel_d;
   logic [ELR_NUM_DEST-1:0] dest_bad;
   logic rd_ready_q;
   logic group_b_fire;
   logic group_e_fire;
   logic [ELR_NUM_SPORT-1:0] sport_fire;
   logic [ELR_NUM_SPORT-1:0] sport_on_e;
   logic [ELR_PORT_W-1:0][ELR_NUM_SPORT-1:0] pin_b_by_sport;
   logic [ELR_PORT_W-1:0][ELR_NUM_SPORT-1:0] pin_e_by_sport;

   assign idx = paddr[ELR_IDX_W+ELR_BYTE_SHIFT-1:ELR_BYTE_SHIFT];
   assign wr_en = psel && penable && pwrite && pready && !pslverr;

   // Answer only once the read word of this transfer is loaded
   assign pready = pclk_en && rd_ready_q;

   // ==========================================
   // Read word ready: set at an enabled edge with psel, cleared when the transfer ends
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_ready_q <= 1'b0;
      end else if (pclk_en) begin
         rd_ready_q <= psel && !(penable && rd_ready_q);
      end
   end
   assign hit_dest = |dest_hit;
   assign hit_any = hit_dest || (|sport_hit) || idx == ELR_IDX_TIMER_OP ||
                    idx == ELR_IDX_CTRL || idx == ELR_IDX_STATUS || idx == ELR_IDX_PGROUP;
   assign pslverr = psel && penable && !hit_any;

   genvar g;
   genvar p;
   generate
      for (g = 0; g < ELR_NUM_DEST; g++) begin : g_dest
         assign dest_hit[g] = (idx == ELR_DEST_IDX[g]);

         // ==========================================
         // Link select register
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               link_select_reg_q[g] <= ELR_SEL_NONE;
            end else if (wr_en && dest_hit[g]) begin
               link_select_reg_q[g] <= pwdata[ELR_SEL_W-1:0];
            end
         end

         // Route: zero selector and unlisted codes give nothing
         assign dest_d[g] = !stop_q && link_select_reg_q[g] != ELR_SEL_NONE &&
                            ELR_VALID_SRC[link_select_reg_q[g]] &&
                            event_src[link_select_reg_q[g]];

         // Selector holds a code with no source
         assign dest_bad[g] = link_select_reg_q[g] != ELR_SEL_NONE && !ELR_VALID_SRC[link_select_reg_q[g]];
      end

      for (g = 0; g < ELR_NUM_SPORT; g++) begin : g_sport
         assign sport_hit[g] = (idx == ELR_IDX_SPORT0 + ELR_IDX_W'(g));

         // ==========================================
         // Single port pin configuration
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sport_cfg_q[g] <= '0;
            end else if (wr_en && sport_hit[g]) begin
               sport_cfg_q[g] <= pwdata[ELR_SP_EN_BIT:0];
            end
         end

         // Single port pin decode
         assign sport_fire[g] = sport_cfg_q[g][ELR_SP_EN_BIT] && dest_d[ELR_POS_SPORT0+g];
         assign sport_on_e[g] = sport_cfg_q[g][ELR_SP_PORT_BIT];
         for (p = 0; p < ELR_PORT_W; p++) begin : g_sport_pin
            assign pin_b_by_sport[p][g] = sport_fire[g] && !sport_on_e[g] &&
                                          sport_cfg_q[g][ELR_PIN_W-1:0] == ELR_PIN_W'(p);
            assign pin_e_by_sport[p][g] = sport_fire[g] && sport_on_e[g] &&
                                          sport_cfg_q[g][ELR_PIN_W-1:0] == ELR_PIN_W'(p);
         end
      end
   endgenerate

   // ==========================================
   // Timer operation, control and port group registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_link_op_reg_q <= ELR_OP_RST;
      end else if (wr_en && idx == ELR_IDX_TIMER_OP) begin
         timer_link_op_reg_q <= pwdata[ELR_OP_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_q <= ELR_STOP_RST;
      end else if (wr_en && idx == ELR_IDX_CTRL) begin
         stop_q <= pwdata[ELR_CTRL_STOP_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pg_mask_b_q <= '0;
         pg_mask_e_q <= '0;
      end else if (wr_en && idx == ELR_IDX_PGROUP) begin
         pg_mask_b_q <= pwdata[ELR_PORT_W-1:0];
         pg_mask_e_q <= pwdata[ELR_PG_E_LSB+ELR_PORT_W-1:ELR_PG_E_LSB];
      end
   end

   // ==========================================
   // Sticky flag: a selector holds a code with no source
   assign badsel_d = |dest_bad;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         badsel_q <= 1'b0;
      end else if (pclk_en) begin
         if (badsel_d) begin
            badsel_q <= 1'b1;
         end else if (wr_en && idx == ELR_IDX_STATUS && pwdata[ELR_STAT_BADSEL_BIT]) begin
            badsel_q <= 1'b0;
         end
      end
   end

   // ==========================================
   // Port B and port E pin events
   assign group_b_fire = dest_d[ELR_POS_OPG1] || dest_d[ELR_POS_IPG1];
   assign group_e_fire = dest_d[ELR_POS_OPG2] || dest_d[ELR_POS_IPG2];

   generate
      for (g = 0; g < ELR_PORT_W; g++) begin : g_pin
         assign port_b_d[g] = (pg_mask_b_q[g] && group_b_fire) || (|pin_b_by_sport[g]);
         assign port_e_d[g] = (pg_mask_e_q[g] && group_e_fire) || (|pin_e_by_sport[g]);
      end
   endgenerate

   // ==========================================
   // Event pulse outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dest_q <= '0;
         port_b_q <= '0;
         port_e_q <= '0;
      end else if (pclk_en) begin
         dest_q <= dest_d;
         port_b_q <= port_b_d;
         port_e_q <= port_e_d;
      end
   end

   // ==========================================
   // Read data
   always_comb begin
      rd_data = ELR_ZERO;
      for (int i = 0; i < ELR_NUM_DEST; i++) begin
         if (dest_hit[i]) begin
            rd_data[ELR_SEL_W-1:0] = link_select_reg_q[i];
         end
      end
      for (int s = 0; s < ELR_NUM_SPORT; s++) begin
         if (sport_hit[s]) begin
            rd_data[ELR_SP_EN_BIT:0] = sport_cfg_q[s];
         end
      end
      if (idx == ELR_IDX_TIMER_OP) begin
         rd_data[ELR_OP_W-1:0] = timer_link_op_reg_q;
      end
      if (idx == ELR_IDX_CTRL) begin
         rd_data[ELR_CTRL_STOP_BIT] = stop_q;
      end
      if (idx == ELR_IDX_STATUS) begin
         rd_data[ELR_STAT_STOP_BIT] = stop_q;
         rd_data[ELR_STAT_BADSEL_BIT] = badsel_q;
      end
      if (idx == ELR_IDX_PGROUP) begin
         rd_data[ELR_PORT_W-1:0] = pg_mask_b_q;
         rd_data[ELR_PG_E_LSB+ELR_PORT_W-1:ELR_PG_E_LSB] = pg_mask_e_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= ELR_ZERO;
      end else if (pclk_en && psel) begin
         prdata_q <= rd_data;
      end
   end

   assign prdata = prdata_q;
   assign dest_event = dest_q;
   assign lsosc_switch_req = dest_q[ELR_POS_LSOSC];
   assign timer8_link_op_select = timer_link_op_reg_q;
   assign port_b_event = port_b_q;
   assign port_e_event = port_e_q;
   assign module_stopped = stop_q;

endmodule

// ===== hdl/elr_pkg.sv
package elr_pkg;

   // ==========================================
   // Bus and routing sizes
   localparam int ELR_DATA_W = 32;
   localparam int ELR_ADDR_W = 12;
   localparam int ELR_IDX_W = 8;
   localparam int ELR_SEL_W = 8;
   localparam int ELR_NUM_SRC = 256;
   localparam int ELR_NUM_DEST = 25;
   localparam int ELR_NUM_SPORT = 4;
   localparam int ELR_PORT_W = 8;
   localparam int ELR_PIN_W = 3;
   localparam int ELR_OP_W = 2;
   localparam int ELR_BYTE_SHIFT = 2;

   // ==========================================
   // Register indices (byte address is four times the index)
   localparam logic [ELR_IDX_W-1:0] ELR_DEST_IDX [ELR_NUM_DEST] = '{
      8'h00, 8'h03, 8'h04, 8'h07, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0f, 8'h10,
      8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b,
      8'h1c, 8'h1e, 8'h1f, 8'h20, 8'h38};
   localparam logic [ELR_IDX_W-1:0] ELR_IDX_TIMER_OP = 8'h3c;
   localparam logic [ELR_IDX_W-1:0] ELR_IDX_CTRL = 8'h3d;
   localparam logic [ELR_IDX_W-1:0] ELR_IDX_STATUS = 8'h3e;
   localparam logic [ELR_IDX_W-1:0] ELR_IDX_PGROUP = 8'h3f;
   localparam logic [ELR_IDX_W-1:0] ELR_IDX_SPORT0 = 8'h40;

   // ==========================================
   // Positions of special destinations in the select table
   localparam int ELR_POS_OPG1 = 12;
   localparam int ELR_POS_OPG2 = 13;
   localparam int ELR_POS_IPG1 = 14;
   localparam int ELR_POS_IPG2 = 15;
   localparam int ELR_POS_SPORT0 = 16;
   localparam int ELR_POS_LSOSC = 20;

   // ==========================================
   // Field layouts and reset values
   localparam int ELR_CTRL_STOP_BIT = 0;
   localparam int ELR_STAT_STOP_BIT = 0;
   localparam int ELR_STAT_BADSEL_BIT = 1;
   localparam int ELR_PG_E_LSB = 8;
   localparam int ELR_SP_PORT_BIT = 3;
   localparam int ELR_SP_EN_BIT = 4;
   localparam logic [ELR_SEL_W-1:0] ELR_SEL_NONE = 8'h00;
   localparam logic [ELR_OP_W-1:0] ELR_OP_RST = 2'h0;
   localparam logic ELR_STOP_RST = 1'b0;
   localparam logic [ELR_DATA_W-1:0] ELR_ZERO = 32'h0000_0000;

   // ==========================================
   // Selector codes that name a real source
   function automatic logic [ELR_NUM_SRC-1:0] elr_in(input int lo, input int hi);
      logic [ELR_NUM_SRC-1:0] m;
      m = '0;
      for (int i = lo; i <= hi; i++) begin
         m[i] = 1'b1;
      end
      return m;
   endfunction

   localparam logic [ELR_NUM_SRC-1:0] ELR_VALID_SRC =
      elr_in(8'h01, 8'h07) | elr_in(8'h10, 8'h1a) | elr_in(8'h1e, 8'h2d) |
      elr_in(8'h37, 8'h37) | elr_in(8'h3c, 8'h47);

endpackage

// ===== testbench/elr_top_monitor.sv
`timescale 1ns/1ps
// ==========================================
// Port checks for the event router
module elr_top_monitor (
   input logic pclk,
   input logic presetn,
   input logic pclk_en,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [elr_pkg::ELR_ADDR_W-1:0] paddr,
   input logic pslverr,
   input logic [elr_pkg::ELR_NUM_SRC-1:0] event_src,
   input logic [elr_pkg::ELR_NUM_DEST-1:0] dest_event,
   input logic lsosc_switch_req,
   input logic [elr_pkg::ELR_OP_W-1:0] timer8_link_op_select,
   input logic [elr_pkg::ELR_PORT_W-1:0] port_b_event,
   input logic [elr_pkg::ELR_PORT_W-1:0] port_e_event,
   input logic module_stopped
);
   import elr_pkg::*;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic wr_acc;
   assign wr_acc = psel && penable && pwrite;
   property p_stop; module_stopped |=> dest_event == '0; endproperty
   property p_quiet; pclk_en && event_src == '0 |=> dest_event == '0; endproperty
   property p_lsosc;
      lsosc_switch_req |-> dest_event[ELR_POS_LSOSC] && $past(!module_stopped);
   endproperty
   property p_pin; (port_b_event | port_e_event) != '0 |-> $past(event_src) != '0; endproperty
   property p_op; !$stable(timer8_link_op_select) |-> $past(wr_acc && paddr[9:2] == ELR_IDX_TIMER_OP); endproperty
   property p_ctl; !$stable(module_stopped) |-> $past(wr_acc && paddr[9:2] == ELR_IDX_CTRL); endproperty
   property p_unmap; psel && penable && paddr[9:2] inside {8'h02, 8'h05} |-> pslverr; endproperty
   property p_map; psel && penable && paddr[9:2] inside {8'h00, 8'h20, 8'h38} |-> !pslverr; endproperty
   a_stop: assert property (p_stop) else $error("event in stop");
   a_quiet: assert property (p_quiet) else $error("event without source");
   a_lsosc: assert property (p_lsosc) else $error("clock switch mismatch");
   a_pin: assert property (p_pin) else $error("pin event without source");
   a_op: assert property (p_op) else $error("op select changed");
   a_ctl: assert property (p_ctl) else $error("stop changed");
   a_unmap: assert property (p_unmap) else $error("no error on hole");
   a_map: assert property (p_map) else $error("error on register");
   cover property (dest_event != '0);
   cover property (port_b_event != '0);
   cover property (pslverr);
endmodule
bind elr_top elr_top_monitor elr_top_monitor_inst (.pclk, .presetn, .pclk_en, .psel, .penable, .pwrite,
   .paddr, .pslverr, .event_src, .dest_event, .lsosc_switch_req, .timer8_link_op_select, .port_b_event,
   .port_e_event, .module_stopped);

// ===== testbench/elr_event_src_model.sv
`timescale 1ns/1ps
// ==========================================
// Source peripherals giving one-cycle events
module elr_event_src_model (
   input logic pclk,
   input logic presetn,
   input logic fire,
   input logic [elr_pkg::ELR_SEL_W-1:0] code,
   output logic [elr_pkg::ELR_NUM_SRC-1:0] event_src
);
   import elr_pkg::*;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_src <= '0;
      end else begin
         event_src <= fire ? (ELR_NUM_SRC'(1) << code) : '0;
      end
   end
endmodule

// ===== testbench/elr_top_test.sv
`timescale 1ns/1ps
// ==========================================
// Event router bench
module elr_top_test;
   import elr_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, pclk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [ELR_ADDR_W-1:0] paddr = '0;
   logic [ELR_DATA_W-1:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, lsosc_switch_req, module_stopped, err, fire = 1'b0;
   logic [ELR_SEL_W-1:0] code = '0;
   logic [ELR_NUM_SRC-1:0] event_src;
   logic [ELR_NUM_DEST-1:0] dest_event;
   logic [ELR_OP_W-1:0] timer8_link_op_select;
   logic [ELR_PORT_W-1:0] port_b_event, port_e_event;
   int num_errors = 0, comparisons = 0;
   logic [7:0] codes [16] = '{8'h01, 8'h06, 8'h07, 8'h10, 8'h14, 8'h15, 8'h1a, 8'h1e,
      8'h22, 8'h23, 8'h28, 8'h29, 8'h2d, 8'h37, 8'h3c, 8'h47};
   always #5 pclk = ~pclk;
   elr_top elr_top_inst (.pclk, .presetn, .pclk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .event_src, .dest_event, .lsosc_switch_req, .timer8_link_op_select,
      .port_b_event, .port_e_event, .module_stopped);
   elr_event_src_model elr_event_src_model_inst (.pclk, .presetn, .fire, .code, .event_src);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      logic ready;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
         ready = pready;
         rd = prdata;
         err = pslverr;
         @(posedge pclk);
      end while (ready !== 1'b1 && n < 50);
      if (ready !== 1'b1) begin
         num_errors++;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic pulse(input logic [7:0] c);
      @(posedge pclk);
      fire <= 1'b1;
      code <= c;
      @(posedge pclk);
      fire <= 1'b0;
      @(posedge pclk);
      #1;
   endtask
   task automatic t_regs();
      apb(1'b0, 12'h000, '0);
      check(rd, ELR_ZERO);
      check(timer8_link_op_select, ELR_OP_RST);
      apb(1'b1, 12'h008, 32'hff);
      check(err, 1'b1);
      apb(1'b0, 12'h014, '0);
      check(err, 1'b1);
      check(rd, ELR_ZERO);
      apb(1'b1, 12'h000, 32'h08);
      apb(1'b1, 12'h0f8, 32'h2);
      apb(1'b0, 12'h0f8, '0);
      check(rd, 32'h2);
      apb(1'b1, 12'h000, '0);
      apb(1'b1, 12'h0f8, 32'h2);
      apb(1'b0, 12'h0f8, '0);
      check(rd, ELR_ZERO);
   endtask
   task automatic t_codes();
      foreach (codes[i]) begin
         apb(1'b1, 12'h000, {24'h0, codes[i]});
         pulse(codes[i]);
         check(dest_event, 25'h1);
         pulse(codes[i] + 8'h01);
         check(dest_event, 25'h0);
      end
   endtask
   task automatic t_map();
      for (int k = 0; k < ELR_NUM_DEST; k++) begin
         apb(1'b1, {2'b00, ELR_DEST_IDX[k], 2'b00}, 32'hffff_ff37);
         apb(1'b0, {2'b00, ELR_DEST_IDX[k], 2'b00}, '0);
         check(err, 1'b0);
         check(rd, 32'h37);
         pulse(8'h37);
         check(dest_event, 25'h1 << k);
         check(lsosc_switch_req, k == ELR_POS_LSOSC);
         apb(1'b1, {2'b00, ELR_DEST_IDX[k], 2'b00}, '0);
         pulse(8'h37);
         check(dest_event, 25'h0);
      end
   endtask
   task automatic t_op();
      for (int v = 0; v < 4; v++) begin
         apb(1'b1, 12'h0f0, v);
         check(timer8_link_op_select, v);
         apb(1'b0, 12'h0f0, '0);
         check(rd, v);
      end
   endtask
   task automatic t_ports();
      apb(1'b1, 12'h0fc, 32'h3ca5);
      apb(1'b1, 12'h050, 32'h3c);
      apb(1'b1, 12'h054, 32'h3c);
      pulse(8'h3c);
      check({port_e_event, port_b_event}, 16'h3ca5);
      apb(1'b1, 12'h050, '0);
      apb(1'b1, 12'h054, '0);
      apb(1'b1, 12'h100, 32'h1d);
      apb(1'b1, 12'h060, 32'h3c);
      pulse(8'h3c);
      check({port_e_event, port_b_event}, 16'h2000);
   endtask
   task automatic t_stop();
      apb(1'b1, 12'h000, 32'h01);
      apb(1'b1, 12'h0f4, 32'h1);
      check(module_stopped, 1'b1);
      pulse(8'h01);
      check(dest_event, 25'h0);
      apb(1'b1, 12'h0f4, 32'h0);
      pulse(8'h01);
      check(dest_event, 25'h1);
      @(posedge pclk);
      pclk_en <= 1'b0;
      pulse(8'h01);
      check(dest_event, 25'h0);
      check(module_stopped, 1'b0);
      @(posedge pclk);
      pclk_en <= 1'b1;
      pulse(8'h01);
      check(dest_event, 25'h1);
   endtask
   task automatic stop_test();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_codes();
      t_map();
      t_op();
      t_ports();
      t_stop();
      stop_test();
   end
   initial begin
      #100000;
      num_errors++;
      stop_test();
   end
endmodule
